// ==== hw/pps_pkg.sv ====
/*
 pps_pkg: constants shared by the power-state control block.
 Assumes inclusion before any pps_ module.
*/
package pps_pkg;
  // configuration-space byte offset of the power control register
  localparam logic [7:0] PPS_PMCR_OFFSET    = 8'hC4;
  // power-state field inside that register
  localparam int         PPS_STATE_LSB      = 0;
  localparam int         PPS_STATE_W        = 2;
  // wake status bit inside the wake status register
  localparam int         PPS_WAKE_STS_BIT   = 15;
  localparam int         PPS_WAKE_W         = 32;
  localparam logic [31:0] PPS_WAKE_RST      = 32'h0000_0000;
  // bus states
  localparam logic [1:0] PPS_B0             = 2'h0;
  localparam logic [1:0] PPS_B1             = 2'h1;
  // clock figures
  localparam int         PPS_CLK_HZ         = 25_000_000;
  localparam int         PPS_MIN_FRAME_HZ   = 16_000_000;
  // length of the internal reset pulse (o_int_rst) less one, in cycles
  localparam int         PPS_IRST_CYCLES    = 16;

  typedef enum logic [1:0] {
    PPS_D0    = 2'h0,
    PPS_D1    = 2'h1,
    PPS_D2    = 2'h2,
    PPS_D3HOT = 2'h3
  } pps_dstate_t;
endpackage

// ==== hw/pps_rst_pulse.sv ====
/*
 pps_rst_pulse: stretches a one-cycle trigger into a fixed-length reset pulse.
 Assumes trigger synchronous to i_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module pps_rst_pulse
  import pps_pkg::*;
#(
  parameter int CYCLES = PPS_IRST_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_trig,
  output logic      o_busy
);
  if (CYCLES < 1 || CYCLES > 255) begin : g_bad_cycles
    $error("pps_rst_pulse: CYCLES out of range");
  end

  logic [7:0] cnt_q;
  wire        cnt_nz = (cnt_q != 8'h00);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q  <= 8'h00;
      o_busy <= 1'b0;
    end else begin
      if (i_trig) cnt_q <= 8'(CYCLES);
      else if (cnt_nz) cnt_q <= cnt_q - 8'h01;
      o_busy <= i_trig | (cnt_q > 8'h01);
    end
  end
endmodule
`default_nettype wire

// ==== hw/pps_ctrl.sv ====
/*
 pps_ctrl: power-state control of a PCI network controller. Holds the power
 state, gates host access, frame traffic and wake events, and issues the
 internal reset on D3hot to D0.
 Assumes the config decoder gives one-cycle write strobes on i_clk; the wake
 event input and bus-state pins are asynchronous and synchronised here.
*/
// Functional notes
// R1: D0 gives full function, frames need 16 MHz
// R2: D1 answers config only, context kept
// R3: D1 no frames, only wake signalling
// R4: D2 config only, no frames, no wake
// R5: D1 and D2 keep configuration contents
// R6: D2/D3hot config only in B0 or B1
// R7: D3hot answers config while powered, clocked
// R8: D3hot to D0 triggers internal reset
// R9: host must reinitialize after D3hot return
// R10: power-on comes up D0, all defaults
// R11: state held in register at C4
// R12: wake drives event low, sets bit 15
// R13: state codes 00,01,10,11 = D0..D3hot
`timescale 1ns/100ps
`default_nettype none
module pps_ctrl
  import pps_pkg::*;
#(
  parameter int CLK_HZ       = PPS_CLK_HZ,
  parameter int RST_CYCLES   = PPS_IRST_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_cfg_wr,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [1:0]  i_cfg_wdata_state,
  input  wire logic        i_wake_sts_clr,
  input  wire logic        i_wake_en,
  input  wire logic        i_wake_event,
  input  wire logic [1:0]  i_bus_state,
  output logic [1:0]       o_power_state,
  output logic             o_mem_io_en,
  output logic             o_cfg_en,
  output logic             o_tx_en,
  output logic             o_rx_en,
  output logic             o_wake_rx_en,
  output logic             o_pme_n,
  output logic             o_pme_oe,
  output logic [31:0]      o_wake_status,
  output logic             o_int_rst,
  output logic             o_reinit_req,
  output logic             o_clk_ok
);
  if (RST_CYCLES < 1 || RST_CYCLES > 255) begin : g_bad_cycles
    $error("pps_ctrl: RST_CYCLES out of range");
  end

  // pin synchronisers
  logic [1:0] bus_s1_q;
  logic [1:0] bus_s2_q;
  logic       wake_s1_q;
  logic       wake_s2_q;
  logic       wake_s3_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_s1_q  <= PPS_B0;
      bus_s2_q  <= PPS_B0;
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      wake_s3_q <= 1'b0;
    end else begin
      bus_s1_q  <= i_bus_state;
      bus_s2_q  <= bus_s1_q;
      wake_s1_q <= i_wake_event;
      wake_s2_q <= wake_s1_q;
      wake_s3_q <= wake_s2_q;
    end
  end

  wire wake_rise = wake_s2_q & ~wake_s3_q;
  wire bus_b01   = (bus_s2_q == PPS_B0) || (bus_s2_q == PPS_B1);

  // power state register
  pps_dstate_t state_q;
  pps_dstate_t state_d;
  logic        irst_busy;

  wire pmcr_hit  = i_cfg_wr && (i_cfg_addr == PPS_PMCR_OFFSET);  // R11
  wire leave_d3  = pmcr_hit && (state_q == PPS_D3HOT) && (pps_dstate_t'(i_cfg_wdata_state) == PPS_D0);
  wire in_d0     = (state_q == PPS_D0);
  // enables follow the state being written, so they move with o_power_state
  wire nx_d0     = (state_d == PPS_D0);
  wire nx_d1     = (state_d == PPS_D1);
  wire nx_d2d3   = (state_d == PPS_D2) || (state_d == PPS_D3HOT);

  always_comb begin
    state_d = state_q;
    if (pmcr_hit) state_d = pps_dstate_t'(i_cfg_wdata_state);  // R13
  end

  // internal reset on return from D3hot
  pps_rst_pulse #(
    .CYCLES (RST_CYCLES)
  ) u_rst (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_trig  (leave_d3),  // R8
    .o_busy  (irst_busy)
  );

  // gating decisions
  wire cfg_ok   = nx_d2d3 ? bus_b01 : 1'b1;  // R6 R7 R2
  // dark from the exit edge on, before the pulse counter is loaded
  wire traffic  = nx_d0 && !irst_busy && !leave_d3;  // R1 R3 R4
  wire wake_ok  = (nx_d0 || nx_d1) && i_wake_en;  // R3 R4
  wire wake_hit = wake_ok && wake_rise;
  wire clk_fast = (CLK_HZ >= PPS_MIN_FRAME_HZ);  // R1

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q       <= PPS_D0;  // R10
      o_power_state <= 2'h0;
      o_mem_io_en   <= 1'b0;
      o_cfg_en      <= 1'b0;
      o_tx_en       <= 1'b0;
      o_rx_en       <= 1'b0;
      o_wake_rx_en  <= 1'b0;
      o_pme_n       <= 1'b1;
      o_pme_oe      <= 1'b0;
      o_wake_status <= PPS_WAKE_RST;
      o_int_rst     <= 1'b0;
      o_reinit_req  <= 1'b0;
      o_clk_ok      <= 1'b0;
    end else begin
      state_q       <= state_d;  // R5
      o_power_state <= state_d;
      o_mem_io_en   <= traffic;  // R2
      o_cfg_en      <= cfg_ok;
      o_tx_en       <= traffic && clk_fast;
      o_rx_en       <= traffic && clk_fast;
      o_wake_rx_en  <= wake_ok;
      o_int_rst     <= irst_busy | leave_d3;  // R8
      // set wins over clear; pme drives low while status set
      if (wake_hit) begin
        o_wake_status[PPS_WAKE_STS_BIT] <= 1'b1;  // R12
        o_pme_n                         <= 1'b0;
        o_pme_oe                        <= 1'b1;
      end else if (i_wake_sts_clr) begin
        o_wake_status[PPS_WAKE_STS_BIT] <= 1'b0;
        o_pme_n                         <= 1'b1;
        o_pme_oe                        <= 1'b0;
      end
      if (leave_d3) o_reinit_req <= 1'b1;  // R9
      else if (pmcr_hit && in_d0) o_reinit_req <= 1'b0;
      o_clk_ok <= clk_fast;
    end
  end
endmodule
`default_nettype wire

// ==== verif/pps_ctrl_monitor.sv ====
/* pps_ctrl_monitor: port checks of pps_ctrl.
 Assumes RST_CYCLES=2 at the bound instance. */
`timescale 1ns/100ps
`default_nettype none
module pps_ctrl_monitor (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_cfg_wr,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [1:0]  i_cfg_wdata_state,
  input  wire logic [1:0]  o_power_state,
  input  wire logic        o_mem_io_en,
  input  wire logic        o_tx_en,
  input  wire logic        o_wake_rx_en,
  input  wire logic        o_pme_n,
  input  wire logic        o_pme_oe,
  input  wire logic [31:0] o_wake_status,
  input  wire logic        o_int_rst,
  input  wire logic        o_reinit_req
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire c4 = i_cfg_wr && i_cfg_addr == 8'hC4;
  a_state_write: assert property (c4 |=> o_power_state == $past(i_cfg_wdata_state)) else $error("bad state");
  a_other_addr: assert property (i_cfg_wr && !c4 |=> $stable(o_power_state)) else $error("moved");
  a_d1_quiet: assert property (o_power_state == 2'h1 |-> !o_tx_en && !o_mem_io_en) else $error("d1 open");
  a_d2_no_wake: assert property (o_power_state == 2'h2 |-> !o_wake_rx_en && !o_tx_en) else $error("d2 open");
  a_d3_exit: assert property ($past(o_power_state) == 2'h3 && o_power_state == 2'h0 |-> o_int_rst && o_reinit_req)
    else $error("no reset");
  a_rst_len: assert property ($rose(o_int_rst) |-> o_int_rst [*3] ##1 !o_int_rst) else $error("rst length");
  a_rst_dark: assert property (o_int_rst |-> !o_tx_en && !o_mem_io_en) else $error("open in reset");
  a_pme_drive: assert property (o_wake_status[15] == !o_pme_n && o_pme_oe == !o_pme_n) else $error("pme");
  a_sts_others: assert property (o_wake_status[31:16] == 16'h0000 && o_wake_status[14:0] == 15'h0000)
    else $error("stray status bit");
endmodule
bind pps_ctrl pps_ctrl_monitor u_mon (.*);
`default_nettype wire

// ==== verif/pps_host_model.sv ====
/* pps_host_model: host issuing config writes.
 Assumes writes are driven after the falling edge. */
`timescale 1ns/100ps
`default_nettype none
module pps_host_model (
  input  wire logic  i_clk,
  output logic       o_wr,
  output logic [7:0] o_addr,
  output logic [1:0] o_data
);
  initial begin
    o_wr = 1'b0;
    o_addr = 8'h00;
    o_data = 2'h0;
  end
  task wr(input logic [7:0] a, input logic [1:0] d);
    @(negedge i_clk);
    {o_wr, o_addr, o_data} = {1'b1, a, d};
    @(negedge i_clk);
    // released lines show a changed value
    {o_wr, o_addr, o_data} = {1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ==== verif/pps_ctrl_tb_top.sv ====
/* pps_ctrl_tb_top: self-checking bench of pps_ctrl.
 Assumes the host model and bound monitor. */
`timescale 1ns/100ps
`default_nettype none
module pps_ctrl_tb_top;
  logic clk, rst_n, wr, clr, wen, wev, mem, cfg, tx, rx, wrx, pme_n, oe, irst, reinit, clk_ok;
  logic [7:0] addr;
  logic [1:0] wd, bus, st;
  logic [31:0] sts;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  pps_host_model host (.i_clk(clk), .o_wr(wr), .o_addr(addr), .o_data(wd));
  pps_ctrl #(.RST_CYCLES(2)) uut (.i_clk(clk), .i_rst_n(rst_n), .i_cfg_wr(wr), .i_cfg_addr(addr),
    .i_cfg_wdata_state(wd), .i_wake_sts_clr(clr), .i_wake_en(wen), .i_wake_event(wev), .i_bus_state(bus),
    .o_power_state(st), .o_mem_io_en(mem), .o_cfg_en(cfg), .o_tx_en(tx), .o_rx_en(rx), .o_wake_rx_en(wrx),
    .o_pme_n(pme_n), .o_pme_oe(oe), .o_wake_status(sts), .o_int_rst(irst), .o_reinit_req(reinit), .o_clk_ok(clk_ok));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (++cyc == 3000) begin
    n_mismatch++;
    end_of_test;
  end
  task end_of_test;
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [63:0] g, e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task go(int n);
    repeat (n) @(negedge clk);
  endtask
  task t_d1;
    host.wr(8'hC4, 2'h1);
    chk({mem, tx, rx, cfg, wrx}, 5'h03);
    wev = 1'b1;
    go(5);
    chk({pme_n, oe, sts}, {2'h1, 32'h8000});
    clr = 1'b1;
    go(1);
    {clr, wev} = 2'h0;
    go(1);
    chk({pme_n, oe, sts}, {2'h2, 32'h0});
  endtask
  task t_d2;
    host.wr(8'hC4, 2'h2);
    chk({tx, rx, wrx, cfg}, 4'h1);
    wev = 1'b1;
    go(5);
    chk({pme_n, sts}, {1'b1, 32'h0});
    {wev, bus} = 3'h2;
    go(5);
    chk(cfg, 1'b0);
    bus = 2'h0;
    go(5);
    chk(cfg, 1'b1);
  endtask
  task t_d3;
    host.wr(8'hC4, 2'h3);
    chk({st, cfg, tx}, 4'hE);
    host.wr(8'hC0, 2'h0);
    chk(st, 2'h3);
    bus = 2'h3;
    go(4);
    chk(cfg, 1'b0);
    bus = 2'h1;
    go(4);
    chk(cfg, 1'b1);
  endtask
  task t_exit;
    host.wr(8'hC4, 2'h0);
    chk({st, irst, reinit, mem, tx}, 6'h0C);
    go(2);
    chk({irst, tx, mem}, 3'h4);
    go(1);
    chk({irst, tx, mem}, 3'h3);
    host.wr(8'hC4, 2'h0);
    chk({reinit, irst}, 2'h0);
  endtask
  task t_wake;
    wen = 1'b0;
    go(1);
    chk(wrx, 1'b0);
    wev = 1'b1;
    go(5);
    chk({pme_n, oe, sts}, {2'h2, 32'h0});
    {wen, wev} = 2'h2;
    go(3);
    wev = 1'b1;
    go(2);
    clr = 1'b1;
    go(1);
    clr = 1'b0;
    go(1);
    chk({pme_n, oe, sts}, {2'h1, 32'h8000});
  endtask
  task t_cold;
    wev = 1'b0;
    host.wr(8'hC4, 2'h1);
    rst_n = 1'b0;
    go(2);
    chk({st, pme_n, oe, tx, mem, irst}, 7'h10);
    rst_n = 1'b1;
    go(2);
    chk({st, pme_n, oe, sts, tx, mem, irst, reinit}, {4'h2, 32'h0, 4'hC});
  endtask
  initial begin
    {rst_n, clr, wen, wev, bus} = 6'h08;
    go(6);
    rst_n = 1'b1;
    go(2);
    chk({st, pme_n, oe, sts, tx, mem, irst, reinit}, {4'h2, 32'h0, 4'hC});
    chk(clk_ok, 1'b1);
    t_d1;
    t_d2;
    t_d3;
    t_exit;
    t_wake;
    t_cold;
    end_of_test;
  end
endmodule
`default_nettype wire
